// [logic/bst_bsr.sv]
// Boundary register: capture/shift path and latched parallel output
`timescale 1ns/1ps
`default_nettype none

module bst_bsr (
   input  wire logic                     tck_i,
   input  wire logic                     rst_n_i,
   input  wire logic [bst_pkg::BSR_W-1:0] pins_i,
   input  wire logic                     tdi_i,
   input  wire logic                     capture_i,
   input  wire logic                     shift_i,
   input  wire logic                     update_i,
   output logic                          so_o,
   output var  logic [bst_pkg::BSR_W-1:0] par_o
);

   logic [bst_pkg::BSR_W-1:0] sh;
   logic [bst_pkg::BSR_W-1:0] next_sh;
   logic [bst_pkg::BSR_W-1:0] next_par;
   logic [bst_pkg::BSR_W:0]   chain;

   // ****************************************************************
   // Shift path, one cell per pin
   // ****************************************************************
   assign chain[bst_pkg::BSR_W] = tdi_i;

   genvar i;
   generate
      for (i = 0; i < bst_pkg::BSR_W; i++) begin : g_cell
         assign chain[i] = sh[i];
         always_comb begin
            if (shift_i) begin
               next_sh[i] = chain[i+1];
            end else if (capture_i) begin
               next_sh[i] = pins_i[i];
            end else begin
               next_sh[i] = sh[i];
            end
         end
      end
   endgenerate

   assign so_o = sh[0];

   always_ff @(posedge tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh <= '0;
      end else begin
         sh <= next_sh;
      end
   end

   // ****************************************************************
   // Parallel output moves on the falling edge of Update-DR only
   // ****************************************************************
   always_comb begin
      next_par = update_i ? sh : par_o;
   end

   always_ff @(negedge tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         par_o <= '0;
      end else begin
         par_o <= next_par;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_par_steady;
      @(posedge tck_i) disable iff (!rst_n_i)
      !update_i |-> $stable(par_o);
   endproperty
   a_par_steady: assert property (p_par_steady)
      else $error("Parallel output changed outside update");

   property p_capture_pins;
      @(posedge tck_i) disable iff (!rst_n_i)
      capture_i && !shift_i |=> sh == $past(pins_i);
   endproperty
   a_capture_pins: assert property (p_capture_pins)
      else $error("Boundary cells missed pin capture");

endmodule : bst_bsr

`default_nettype wire

// [logic/bst_pkg.sv]
// Constants and types shared by the boundary-scan test port
package bst_pkg;

   // ****************************************************************
   // Register lengths
   // ****************************************************************
   localparam int IR_W  = 3;
   localparam int BSR_W = 8;
   localparam int IDR_W = 32;

   // ****************************************************************
   // Instruction codes and fixed values
   // ****************************************************************
   localparam logic [IR_W-1:0]  IR_CAPTURE = 3'h4;
   localparam logic [IR_W-1:0]  OP_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0]  OP_IDCODE  = 3'h1;
   localparam logic [IR_W-1:0]  OP_SAMPLE  = 3'h2;
   localparam logic [IR_W-1:0]  OP_BYPASS  = 3'h7;
   // Identification word: arbitrary value, bit 0 set as usual
   localparam logic [IDR_W-1:0] IDCODE_VALUE = 32'h0000_0a01;

   // ****************************************************************
   // Controller states
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_RESET  = 4'b0000,
      ST_IDLE   = 4'b0001,
      ST_SEL_DR = 4'b0010,
      ST_CAP_DR = 4'b0011,
      ST_SH_DR  = 4'b0100,
      ST_EX1_DR = 4'b0101,
      ST_PA_DR  = 4'b0110,
      ST_EX2_DR = 4'b0111,
      ST_UPD_DR = 4'b1000,
      ST_SEL_IR = 4'b1001,
      ST_CAP_IR = 4'b1010,
      ST_SH_IR  = 4'b1011,
      ST_EX1_IR = 4'b1100,
      ST_PA_IR  = 4'b1101,
      ST_EX2_IR = 4'b1110,
      ST_UPD_IR = 4'b1111
   } bst_state_t;

endpackage : bst_pkg

// [logic/bst_sync.sv]
// Two-stage synchroniser with enable and asynchronous clear
`timescale 1ns/1ps
`default_nettype none

module bst_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = en_i ? d_i : meta;
      next_q    = en_i ? meta : q_o;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= next_meta;
         q_o  <= next_q;
      end
   end

endmodule : bst_sync

`default_nettype wire

// [logic/bst_tap.sv]
// Test access port controller with its instruction and data registers
`timescale 1ns/1ps
`default_nettype none

module bst_tap (
   input  wire logic                      CLK_I,
   input  wire logic                      RESETN_I,
   input  wire logic                      CE_I,
   input  wire logic                      TCK_I,
   input  wire logic                      TMS_I,
   input  wire logic                      TDI_I,
   input  wire logic [bst_pkg::BSR_W-1:0] PIN_I,
   output var  logic                      TDO_O,
   output var  logic                      TDO_OE_O,
   output var  logic [bst_pkg::BSR_W-1:0] BSR_OUT_O,
   output var  logic                      TEST_MODE_O
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   bst_pkg::bst_state_t       state;
   bst_pkg::bst_state_t       next_state;
   logic                      por_n;
   logic                      next_por_n;
   logic                      tck_rst_n;
   logic                      test_mode_sync;
   logic                      next_test_mode;
   logic [bst_pkg::BSR_W-1:0] pin_sync;
   logic [bst_pkg::IR_W-1:0]  ir_shift;
   logic [bst_pkg::IR_W-1:0]  next_ir_shift;
   logic [bst_pkg::IR_W-1:0]  instr;
   logic [bst_pkg::IR_W-1:0]  next_instr;
   logic                      test_en;
   logic                      next_test_en;
   logic                      bypass;
   logic                      next_bypass;
   logic [bst_pkg::IDR_W-1:0] idr;
   logic [bst_pkg::IDR_W-1:0] next_idr;
   logic                      next_tdo;
   logic                      next_tdo_oe;
   logic                      sel_bsr;
   logic                      sel_id;
   logic                      bsr_so;
   logic                      dr_so;
   logic                      in_cap_dr;
   logic                      in_sh_dr;
   logic                      in_upd_dr;

   // ****************************************************************
   // System clock side: reset source and test-mode output
   // ****************************************************************
   // A low reset on the system clock pulls the TCK side into its reset
   // state asynchronously, so no TCK edge is needed after power-up.
   always_comb begin
      next_por_n = por_n;
      if (CE_I) begin
         next_por_n = 1'b1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         por_n <= 1'b0;
      end else begin
         por_n <= next_por_n;
      end
   end

   // Release of the TCK-side reset is retimed to TCK
   bst_sync #(
      .W (1)
   ) u_rst_sync (
      .clk_i   (TCK_I),
      .rst_n_i (por_n),
      .en_i    (1'b1),
      .d_i     (1'b1),
      .q_o     (tck_rst_n)
   );

   // Test-mode level crosses back to the system clock
   bst_sync #(
      .W (1)
   ) u_mode_sync (
      .clk_i   (CLK_I),
      .rst_n_i (1'b1),
      .en_i    (CE_I),
      .d_i     (test_en),
      .q_o     (test_mode_sync)
   );

   always_comb begin
      next_test_mode = CE_I ? test_mode_sync : TEST_MODE_O;
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         TEST_MODE_O <= 1'b0;
      end else begin
         TEST_MODE_O <= next_test_mode;
      end
   end

   // ****************************************************************
   // Pin inputs retimed to TCK before capture
   // ****************************************************************
   bst_sync #(
      .W (bst_pkg::BSR_W)
   ) u_pin_sync (
      .clk_i   (TCK_I),
      .rst_n_i (tck_rst_n),
      .en_i    (1'b1),
      .d_i     (PIN_I),
      .q_o     (pin_sync)
   );

   // ****************************************************************
   // Controller state machine
   // ****************************************************************
   always_comb begin
      unique case (state)
         bst_pkg::ST_RESET:
            next_state = TMS_I ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:
            next_state = TMS_I ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR:
            next_state = TMS_I ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR:
            next_state = TMS_I ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR:
            next_state = TMS_I ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR:
            next_state = TMS_I ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
         bst_pkg::ST_PA_DR:
            next_state = TMS_I ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
         bst_pkg::ST_EX2_DR:
            next_state = TMS_I ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR:
            next_state = TMS_I ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR:
            next_state = TMS_I ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR:
            next_state = TMS_I ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR:
            next_state = TMS_I ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR:
            next_state = TMS_I ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
         bst_pkg::ST_PA_IR:
            next_state = TMS_I ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
         bst_pkg::ST_EX2_IR:
            next_state = TMS_I ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR:
            next_state = TMS_I ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      endcase
   end

   // Every path with TMS high reaches the reset state within five edges
   always_ff @(posedge TCK_I or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         state <= bst_pkg::ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Instruction register
   // ****************************************************************
   always_comb begin
      next_ir_shift = ir_shift;
      if (state == bst_pkg::ST_CAP_IR) begin
         next_ir_shift = bst_pkg::IR_CAPTURE;
      end else if (state == bst_pkg::ST_SH_IR) begin
         next_ir_shift = {TDI_I, ir_shift[bst_pkg::IR_W-1:1]};
      end
   end

   always_ff @(posedge TCK_I or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_shift <= bst_pkg::IR_CAPTURE;
      end else begin
         ir_shift <= next_ir_shift;
      end
   end

   // Current instruction only moves on the falling edge
   always_comb begin
      next_instr = instr;
      if (state == bst_pkg::ST_RESET) begin
         next_instr = bst_pkg::OP_IDCODE;
      end else if (state == bst_pkg::ST_UPD_IR) begin
         next_instr = ir_shift;
      end
      next_test_en = (next_instr == bst_pkg::OP_EXTEST);
   end

   always_ff @(negedge TCK_I or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         instr   <= bst_pkg::OP_IDCODE;
         test_en <= 1'b0;
      end else begin
         instr   <= next_instr;
         test_en <= next_test_en;
      end
   end

   // ****************************************************************
   // Data registers
   // ****************************************************************
   always_comb begin
      sel_bsr   = (instr == bst_pkg::OP_EXTEST) ||
                  (instr == bst_pkg::OP_SAMPLE);
      sel_id    = (instr == bst_pkg::OP_IDCODE);
      in_cap_dr = (state == bst_pkg::ST_CAP_DR);
      in_sh_dr  = (state == bst_pkg::ST_SH_DR);
      in_upd_dr = (state == bst_pkg::ST_UPD_DR);
   end

   // Bypass has no parallel input, so capture leaves it alone
   always_comb begin
      next_bypass = bypass;
      next_idr    = idr;
      if (in_sh_dr && !sel_bsr && !sel_id) begin
         next_bypass = TDI_I;
      end
      if (sel_id && in_cap_dr) begin
         next_idr = bst_pkg::IDCODE_VALUE;
      end else if (sel_id && in_sh_dr) begin
         next_idr = {TDI_I, idr[bst_pkg::IDR_W-1:1]};
      end
   end

   always_ff @(posedge TCK_I or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bypass <= 1'b0;
         idr    <= bst_pkg::IDCODE_VALUE;
      end else begin
         bypass <= next_bypass;
         idr    <= next_idr;
      end
   end

   bst_bsr u_bsr (
      .tck_i     (TCK_I),
      .rst_n_i   (tck_rst_n),
      .pins_i    (pin_sync),
      .tdi_i     (TDI_I),
      .capture_i (in_cap_dr && sel_bsr),
      .shift_i   (in_sh_dr && sel_bsr),
      .update_i  (in_upd_dr && sel_bsr),
      .so_o      (bsr_so),
      .par_o     (BSR_OUT_O)
   );

   // ****************************************************************
   // Serial output, changed on the falling edge
   // ****************************************************************
   always_comb begin
      dr_so = bypass;
      if (sel_bsr) begin
         dr_so = bsr_so;
      end else if (sel_id) begin
         dr_so = idr[0];
      end
      next_tdo    = TDO_O;
      next_tdo_oe = 1'b0;
      if (state == bst_pkg::ST_SH_IR) begin
         next_tdo    = ir_shift[0];
         next_tdo_oe = 1'b1;
      end else if (in_sh_dr) begin
         next_tdo    = dr_so;
         next_tdo_oe = 1'b1;
      end
   end

   always_ff @(negedge TCK_I or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         TDO_O    <= 1'b0;
         TDO_OE_O <= 1'b0;
      end else begin
         TDO_O    <= next_tdo;
         TDO_OE_O <= next_tdo_oe;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge TCK_I); endclocking
   default disable iff (!tck_rst_n);

   sequence s_five_high;
      TMS_I [*5];
   endsequence

   sequence s_enter_cap_ir;
      state == bst_pkg::ST_SEL_IR && !TMS_I ##1 state == bst_pkg::ST_CAP_IR;
   endsequence

   property p_five_high;
      s_five_high |=> state == bst_pkg::ST_RESET;
   endproperty
   a_five_high: assert property (p_five_high)
      else $error("Five TMS-high edges did not reach reset state");

   property p_reset_state;
      state == bst_pkg::ST_RESET |=> instr == bst_pkg::OP_IDCODE && !test_en;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("Reset state did not restore IDCODE");

   property p_reset_exit;
      state == bst_pkg::ST_RESET && !TMS_I |=> state == bst_pkg::ST_IDLE;
   endproperty
   a_reset_exit: assert property (p_reset_exit)
      else $error("Reset state did not go to Idle");

   property p_idle;
      state == bst_pkg::ST_IDLE |=> state ==
         ($past(TMS_I) ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE);
   endproperty
   a_idle: assert property (p_idle)
      else $error("Wrong exit from Idle");

   property p_sel_dr;
      state == bst_pkg::ST_SEL_DR |=> state ==
         ($past(TMS_I) ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR);
   endproperty
   a_sel_dr: assert property (p_sel_dr)
      else $error("Wrong exit from Select-DR");

   property p_exit1_dr;
      state == bst_pkg::ST_EX1_DR |=> state ==
         ($past(TMS_I) ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR);
   endproperty
   a_exit1_dr: assert property (p_exit1_dr)
      else $error("Wrong exit from Exit1-DR");

   property p_sel_ir;
      state == bst_pkg::ST_SEL_IR |=> state ==
         ($past(TMS_I) ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR);
   endproperty
   a_sel_ir: assert property (p_sel_ir)
      else $error("Wrong exit from Select-IR");

   property p_cap_ir;
      s_enter_cap_ir |=> ir_shift == bst_pkg::IR_CAPTURE;
   endproperty
   a_cap_ir: assert property (p_cap_ir)
      else $error("Capture-IR did not load the fixed pattern");

   property p_shift_ir;
      state == bst_pkg::ST_SH_IR |=>
         ir_shift == {$past(TDI_I), $past(ir_shift[bst_pkg::IR_W-1:1])};
   endproperty
   a_shift_ir: assert property (p_shift_ir)
      else $error("Instruction register did not shift");

   // The falling edge that may move instr lies in the sampled state
   property p_instr_hold;
      state != bst_pkg::ST_UPD_IR && state != bst_pkg::ST_RESET
         |-> $stable(instr);
   endproperty
   a_instr_hold: assert property (p_instr_hold)
      else $error("Instruction changed outside update");

   property p_upd_ir;
      state == bst_pkg::ST_UPD_IR |=> instr == $past(ir_shift);
   endproperty
   a_upd_ir: assert property (p_upd_ir)
      else $error("Update-IR did not latch the instruction");

   property p_tdo_oe;
      1'b1 |-> TDO_OE_O == (state == bst_pkg::ST_SH_DR ||
                            state == bst_pkg::ST_SH_IR);
   endproperty
   a_tdo_oe: assert property (p_tdo_oe)
      else $error("TDO enable outside shift states");

endmodule : bst_tap

`default_nettype wire

// [verification/bst_tester.sv]
// Tester model that drives the scan link from its own test clock
`timescale 1ns/1ps
`default_nettype none

module bst_tester (
   input  wire logic TDO_I,
   output var  logic TCK_O,
   output var  logic TMS_O,
   output var  logic TDI_O
);
   initial begin
      TCK_O = 1'b0;
      TMS_O = 1'b1;
      TDI_O = 1'b0;
   end

   // One 160 ns test clock period, clock idle low between calls
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      TMS_O = tms;
      TDI_O = tdi;
      #80;
      tdo = TDO_I;
      TCK_O = 1'b1;
      #40;
      // Data only counts up to the rising edge; show the inverse after it
      TDI_O = ~tdi;
      #40;
      TCK_O = 1'b0;
   endtask : step
endmodule : bst_tester
`default_nettype wire

// [verification/test_boundary_scan_tap_fsm.sv]
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none

module test_boundary_scan_tap_fsm;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        ce_i = 1'b1;
   logic        tck, tms, tdi, tdo, tdo_oe, test_mode;
   logic [7:0]  pin_i = 8'h00;
   logic [7:0]  bsr_out;
   logic [31:0] seen, din, by_din, by_exp;
   logic        by_last = 1'b0;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cycles = 0;

   bst_tap u_bst_tap (.CLK_I(clk_i), .RESETN_I(resetn_i), .CE_I(ce_i),
      .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .PIN_I(pin_i), .TDO_O(tdo),
      .TDO_OE_O(tdo_oe), .BSR_OUT_O(bsr_out), .TEST_MODE_O(test_mode));
   bst_tester u_bst_tester (.TDO_I(tdo), .TCK_O(tck), .TMS_O(tms),
      .TDI_O(tdi));

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task conclude;
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   task check(input string name, input logic [31:0] exp,
              input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Lets the test-mode path settle, then steps off the clock edge
   task settle;
      repeat (6) @(posedge clk_i);
      #2;
   endtask : settle

   // TMS pattern sent least significant bit first, TDI low at each rising edge
   task move(input logic [7:0] pat, input int n);
      logic d;
      for (int i = 0; i < n; i++) begin
         u_bst_tester.step(pat[i], 1'b0, d);
      end
   endtask : move

   // Full scan from Idle back to Idle, optionally through the pause state
   task scan(input logic ir, input int n, input logic [31:0] data,
             input logic pause, output logic [31:0] dout);
      logic d;
      dout = '0;
      if (ir)
         move(8'h03, 4);
      else
         move(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         u_bst_tester.step(i == n - 1, data[i], d);
         dout[i] = d;
      end
      if (pause)
         move(8'h0c, 5);
      else
         move(8'h01, 2);
   endtask : scan

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h19d8));
      repeat (20) @(posedge clk_i);
      #2;
      resetn_i = 1'b1;
      pin_i = 8'($urandom);
      repeat (2) @(posedge clk_i);
      #13;
      move(8'h7f, 8);
      check("bsr_out_reset", 32'h0, {24'h0, bsr_out});
      scan(1'b0, 32, $urandom, 1'b0, seen);
      check("idcode", bst_pkg::IDCODE_VALUE, seen);
      scan(1'b1, 3, {29'h0, bst_pkg::OP_SAMPLE}, 1'($urandom), seen);
      check("ir_capture", {29'h0, bst_pkg::IR_CAPTURE}, seen);
      check("tdo_oe_idle", 32'h0, {31'h0, tdo_oe});
      din = $urandom;
      scan(1'b0, 8, din, 1'b1, seen);
      check("sample_pins", {24'h0, pin_i}, seen);
      check("bsr_update", {24'h0, din[7:0]}, {24'h0, bsr_out});
      for (int k = 0; k < 2; k++) begin
         scan(1'b1, 3, k ? 32'h5 : {29'h0, bst_pkg::OP_BYPASS}, 1'b0,
              seen);
         by_din = $urandom;
         scan(1'b0, 9, by_din, 1'($urandom), seen);
         // Bypass keeps its bit through capture, then passes TDI on
         by_exp = {23'h0, by_din[7:0], by_last};
         check("bypass_path", by_exp, {23'h0, seen[8:0]});
         by_last = by_din[8];
         check("bsr_hold", {24'h0, din[7:0]}, {24'h0, bsr_out});
      end
      @(posedge clk_i);
      #2;
      ce_i = 1'b0;
      scan(1'b1, 3, {29'h0, bst_pkg::OP_EXTEST}, 1'b0, seen);
      settle();
      check("test_mode_frozen", 32'h0, {31'h0, test_mode});
      ce_i = 1'b1;
      settle();
      check("test_mode_on", 32'h1, {31'h0, test_mode});
      move(8'h07, 4);
      settle();
      check("test_mode_sel_ir", 32'h0, {31'h0, test_mode});
      scan(1'b1, 3, {29'h0, bst_pkg::OP_EXTEST}, 1'b1, seen);
      move(8'h1f, 6);
      settle();
      check("test_mode_five", 32'h0, {31'h0, test_mode});
      // Reset in mid-run with the test clock standing still
      resetn_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #2;
      check("bsr_out_por", 32'h0, {24'h0, bsr_out});
      resetn_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #2;
      move(8'h03, 3);
      scan(1'b0, 32, $urandom, 1'b1, seen);
      check("idcode_again", bst_pkg::IDCODE_VALUE, seen);
      conclude();
   end
endmodule : test_boundary_scan_tap_fsm
`default_nettype wire
